// [core/rsmc_top.sv]
/*
 Reset and supply monitor control: power-on delay, supply monitor reset path,
 software reset, monitor control and reset cause registers, core reset image.
 Assumes presetn is the power-on reset, a supply comparator output on a pin,
 and an external open-drain reset pin with pull-up.
*/
`timescale 1ns/1ns
module rsmc_top
	import rsmc_pkg::*;
#(
	parameter int POR_DELAY_CYC = RSMC_POR_DELAY_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        supply_above,
	output logic             supply_monitor_enable,
	output logic             supply_threshold_select,
	output logic             rst_pin_o,
	output logic             rst_pin_oe,
	output logic             core_rst_n,
	output rsmc_core_t       core
);

	////////////////////////////////////////////////////////////////////////
	// Supply comparator input
	logic above_s;

	// Comparator edges near the threshold chatter; the agreement filter
	// keeps one noisy sample from starting or ending a monitor reset.
	rsmc_sync3 #(
		.RST_VAL (1'b0)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (supply_above),
		.dout    (above_s)
	);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef enum logic [1:0] {
		RSMC_S_POR_WAIT,
		RSMC_S_POR_DELAY,
		RSMC_S_RUN,
		RSMC_S_MON_HOLD
	} rsmc_state_t;

	rsmc_state_t state_q;
	rsmc_state_t state_d;
	logic [31:0] dly_q;
	logic [31:0] dly_d;
	logic        mon_en_q;
	logic        mon_en_d;
	logic        thr_q;
	logic        thr_d;
	logic        mon_sel_q;
	logic        mon_sel_d;
	logic        por_flag_q;
	logic        por_flag_d;
	logic        sw_flag_q;
	logic        sw_flag_d;
	logic        sw_req_q;
	logic        sw_req_d;
	logic        sw_hold_q;
	logic        sw_hold_d;
	logic        core_arst_n;
	logic        core_srst_n;
	logic        wr_en;
	logic        rd_en;
	logic        mon_fault;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic        err_d;
	logic        err_q;
	logic        hit_ctrl;
	logic        hit_cause;
	logic        hit_stat;
	logic        hit_src;
	logic        hit_wr;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	// Monitor can only reset when both enabled and selected; selecting it
	// while the comparator still reads low resets immediately.
	assign mon_fault = mon_en_q && mon_sel_q && !above_s;

	always_comb begin
		state_d    = state_q;
		dly_d      = dly_q;
		mon_en_d   = mon_en_q;
		thr_d      = thr_q;
		mon_sel_d  = mon_sel_q;
		por_flag_d = por_flag_q;
		sw_flag_d  = sw_flag_q;
		sw_req_d   = 1'b0;
		sw_hold_d  = 1'b0;
		case (state_q)
			RSMC_S_POR_WAIT: begin
				dly_d = '0;
				if (above_s) begin
					state_d = RSMC_S_POR_DELAY;
				end
			end
			// A dip during the delay restarts the whole wait, so a slow ramp
			// cannot release the core on a brief spike above the threshold.
			RSMC_S_POR_DELAY: begin
				if (!above_s) begin
					state_d = RSMC_S_POR_WAIT;
				end else if (dly_q >= 32'(POR_DELAY_CYC - 1)) begin
					state_d    = RSMC_S_RUN;
					por_flag_d = 1'b1;
				end else begin
					dly_d = dly_q + 32'd1;
				end
			end
			RSMC_S_RUN: begin
				if (mon_fault) begin
					state_d    = RSMC_S_MON_HOLD;
					por_flag_d = 1'b1;
				end else if (sw_req_q) begin
					sw_hold_d  = 1'b1;
					por_flag_d = 1'b0;
					sw_flag_d  = 1'b1;
					// Monitor enable and selection survive a software reset
				end else if (wr_en && paddr[13:0] == RSMC_ADDR_MON_CTRL) begin
					mon_en_d = pwdata[RSMC_BIT_MON_EN];
					thr_d    = pwdata[RSMC_BIT_THRESH_SEL];
				end else if (wr_en && paddr[13:0] == RSMC_ADDR_CAUSE) begin
					if (pwdata[RSMC_BIT_POR_FLAG]) begin
						mon_sel_d = 1'b1;
					end
					sw_req_d = pwdata[RSMC_BIT_SW_RESET];
				end
			end
			RSMC_S_MON_HOLD: begin
				// Release straight to run, no power-on delay
				if (above_s) begin
					state_d = RSMC_S_RUN;
				end
			end
			default: begin
				state_d = RSMC_S_POR_WAIT;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= RSMC_S_POR_WAIT;
			dly_q      <= '0;
			mon_en_q   <= 1'b1;
			thr_q      <= RSMC_THRESH_RST;
			mon_sel_q  <= 1'b1;
			por_flag_q <= 1'b0;
			sw_flag_q  <= 1'b0;
			sw_req_q   <= 1'b0;
			sw_hold_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			dly_q      <= dly_d;
			mon_en_q   <= mon_en_d;
			thr_q      <= thr_d;
			mon_sel_q  <= mon_sel_d;
			por_flag_q <= por_flag_d;
			sw_flag_q  <= sw_flag_d;
			sw_req_q   <= sw_req_d;
			sw_hold_q  <= sw_hold_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core reset: any active source asserts at once, release is synchronised
	assign core_arst_n = presetn && (state_q == RSMC_S_RUN) && !mon_fault && !sw_hold_q;

	// Release is synchronised so every core flop leaves reset on one edge;
	// assertion stays asynchronous and needs no running clock.
	rsmc_rst_sync u_rel (
		.pclk   (pclk),
		.arst_n (core_arst_n),
		.srst_n (core_srst_n)
	);

	assign core_rst_n = core_srst_n;

	// Pin is driven only for power-on and monitor resets
	assign rst_pin_o  = 1'b0;
	assign rst_pin_oe = !presetn || (state_q != RSMC_S_RUN) || mon_fault;

	assign supply_monitor_enable   = mon_en_q;
	assign supply_threshold_select = thr_q;

	////////////////////////////////////////////////////////////////////////
	// Core reset image; data memory is not listed, so it keeps its contents
	always_comb begin
		core.halt             = !core_srst_n;
		core.irq_timer_off    = !core_srst_n;
		core.sfr_init         = !core_srst_n;
		core.port_latch       = RSMC_PORT_LATCH_RST;
		core.port_open_drain  = !core_srst_n;
		core.weak_pullup      = 1'b1;
		core.pc               = RSMC_START_ADDR;
		core.clk_internal_osc = 1'b1;
		core.wdt_enable       = 1'b1;
		core.wdt_div          = RSMC_WDT_DIV;
	end

	////////////////////////////////////////////////////////////////////////
	// APB read path: data registered in setup, no wait states (pready tied high)
	always_comb begin
		rdata_d = rdata_q;
		err_d   = err_q;
		if (rd_en) begin
			// The error of a read is latched in setup, together with its data
			rdata_d = '0;
			err_d   = 1'b0;
			if (paddr[13:0] == RSMC_ADDR_MON_CTRL) begin
				rdata_d[RSMC_BIT_MON_EN]     = mon_en_q;
				rdata_d[RSMC_BIT_LEVEL_STAT] = above_s;
				rdata_d[RSMC_BIT_THRESH_SEL] = thr_q;    // bits 4:0 zero
			end else if (paddr[13:0] == RSMC_ADDR_CAUSE) begin
				rdata_d[RSMC_BIT_POR_FLAG] = por_flag_q;
				rdata_d[RSMC_BIT_SW_RESET] = sw_flag_q && !por_flag_q;
			end else if (paddr[13:0] == RSMC_ADDR_CORE_STAT) begin
				rdata_d[0] = core_srst_n;
				rdata_d[1] = rst_pin_oe;
				rdata_d[2] = mon_sel_q;
			end else if (paddr[13:0] == RSMC_ADDR_SRC_IN) begin
				rdata_d[0] = above_s;
			end else begin
				err_d = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= '0;
			err_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			err_q   <= err_d;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = rdata_q;
	////////////////////////////////////////////////////////////////////////
	// Address decode for the write error; paddr above bit 13 is ignored,
	// so the map repeats every 16 kB of the bus.
	always_comb begin
		hit_ctrl  = 1'b0;
		hit_cause = 1'b0;
		hit_stat  = 1'b0;
		hit_src   = 1'b0;
		if (paddr[13:0] == RSMC_ADDR_MON_CTRL) begin
			hit_ctrl = 1'b1;
		end else if (paddr[13:0] == RSMC_ADDR_CAUSE) begin
			hit_cause = 1'b1;
		end else if (paddr[13:0] == RSMC_ADDR_CORE_STAT) begin
			hit_stat = 1'b1;
		end else if (paddr[13:0] == RSMC_ADDR_SRC_IN) begin
			hit_src = 1'b1;
		end
	end

	// Only control and cause take writes; a store to a status word is
	// flagged so software notices it instead of losing it silently.
	assign hit_wr = hit_ctrl || hit_cause;

	// Writes are checked combinationally, reads use the error from setup
	assign pslverr = psel && penable && (pwrite ? !hit_wr : err_q);

endmodule // rsmc_top

// [core/rsmc_pkg.sv]
/*
 Package for the reset and supply monitor control block: register map, field
 positions, reset values, timing constants and the status carrier struct.
 Assumes a 32-bit APB register bus and a 125 MHz pclk.
*/
package rsmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses; printed offset 0xFF is not word aligned)
	localparam logic [11:0] RSMC_IDX_MON_CTRL   = 12'h0FF;
	localparam logic [11:0] RSMC_IDX_CAUSE      = 12'h0EF;
	localparam logic [11:0] RSMC_IDX_CORE_STAT  = 12'h100;
	localparam logic [11:0] RSMC_IDX_SRC_IN     = 12'h101;
	localparam logic [13:0] RSMC_ADDR_MON_CTRL  = {RSMC_IDX_MON_CTRL, 2'b00};
	localparam logic [13:0] RSMC_ADDR_CAUSE     = {RSMC_IDX_CAUSE, 2'b00};
	localparam logic [13:0] RSMC_ADDR_CORE_STAT = {RSMC_IDX_CORE_STAT, 2'b00};
	localparam logic [13:0] RSMC_ADDR_SRC_IN    = {RSMC_IDX_SRC_IN, 2'b00};

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int RSMC_BIT_MON_EN     = 7;
	localparam int RSMC_BIT_LEVEL_STAT = 6;
	localparam int RSMC_BIT_THRESH_SEL = 5;
	localparam int RSMC_BIT_POR_FLAG   = 1;
	localparam int RSMC_BIT_SW_RESET   = 4;

	////////////////////////////////////////////////////////////////////////
	// Reset values and startup state
	localparam logic [7:0]  RSMC_PORT_LATCH_RST = 8'hFF;
	localparam logic [15:0] RSMC_START_ADDR     = 16'h0000;
	localparam logic [3:0]  RSMC_WDT_DIV        = 4'hC;
	localparam logic        RSMC_THRESH_RST     = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int RSMC_CLK_MHZ        = 125;
	localparam int RSMC_POR_DELAY_US   = 300;
	localparam int RSMC_POR_DELAY_CYC  = RSMC_POR_DELAY_US * RSMC_CLK_MHZ;
	localparam int RSMC_REL_SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		RSMC_CAUSE_POR,
		RSMC_CAUSE_MON,
		RSMC_CAUSE_SW
	} rsmc_cause_t;

	// Core-facing reset image
	typedef struct packed {
		logic        halt;
		logic        irq_timer_off;
		logic [7:0]  port_latch;
		logic        port_open_drain;
		logic        weak_pullup;
		logic [15:0] pc;
		logic        clk_internal_osc;
		logic        wdt_enable;
		logic [3:0]  wdt_div;
		logic        sfr_init;
	} rsmc_core_t;

endpackage : rsmc_pkg

// [core/rsmc_sync3.sv]
/*
 Three-stage pin synchroniser with agreement filter: the output follows once
 the second and third stages agree. Assumes an asynchronous input.
*/
`timescale 1ns/1ns
module rsmc_sync3
	import rsmc_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);

	logic [2:0] sh_q;
	logic [2:0] sh_d;
	logic       out_q;
	logic       out_d;

	always_comb begin
		sh_d  = {sh_q[1:0], din};
		out_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : out_q;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_q  <= {3{RST_VAL}};
			out_q <= RST_VAL;
		end else begin
			sh_q  <= sh_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;

endmodule // rsmc_sync3

// [core/rsmc_rst_sync.sv]
/*
 Reset release synchroniser: asserts asynchronously, releases after two
 pclk edges. Assumes arst_n may fall at any time.
*/
`timescale 1ns/1ns
module rsmc_rst_sync
	import rsmc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic arst_n,
	output logic      srst_n
);

	logic [RSMC_REL_SYNC_STAGES-1:0] st_q;
	logic [RSMC_REL_SYNC_STAGES-1:0] st_d;

	always_comb begin
		st_d = {st_q[RSMC_REL_SYNC_STAGES-2:0], 1'b1};
	end

	always_ff @(posedge pclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign srst_n = st_q[RSMC_REL_SYNC_STAGES-1];

endmodule // rsmc_rst_sync

// [tb/rsmc_props.sv]
/* Port checker for rsmc_top.
 Assumes a bind onto rsmc_top; sees only its ports. */
`timescale 1ns/1ns
module rsmc_props
	import rsmc_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        supply_above,
	input wire logic        supply_monitor_enable,
	input wire logic        supply_threshold_select,
	input wire logic        rst_pin_oe,
	input wire logic        core_rst_n,
	input wire rsmc_core_t  core
);
	wire mon_acc = psel && penable && paddr == {18'h0, RSMC_ADDR_MON_CTRL};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_pin_por_hold: assert property ($rose(presetn) |-> rst_pin_oe && !core_rst_n)
		else $error("pin released with power-on");
	a_core_image: assert property (core.port_latch == 8'hFF && core.weak_pullup
		&& core.pc == 16'h0000 && core.clk_internal_osc && core.wdt_enable && core.wdt_div == 4'hC)
		else $error("core reset image wrong");
	a_halt_tracks: assert property (core.halt == !core_rst_n && core.sfr_init == !core_rst_n
		&& core.irq_timer_off == !core_rst_n && core.port_open_drain == !core_rst_n)
		else $error("halt image does not follow reset");
	a_fault_pin: assert property ((supply_monitor_enable && !supply_above)[*6] |->
		rst_pin_oe && !core_rst_n) else $error("low supply did not reset");
	a_off_no_pin: assert property (!supply_monitor_enable |-> !rst_pin_oe)
		else $error("disabled monitor drives pin");
	a_release_sync: assert property ($fell(rst_pin_oe) |-> ##[1:3] core_rst_n)
		else $error("core reset release late");
	a_ctrl_write: assert property (core_rst_n && mon_acc && pwrite |=>
		supply_monitor_enable == $past(pwdata[7]) && supply_threshold_select == $past(pwdata[5]))
		else $error("control write not applied");
	a_rd_unused: assert property (mon_acc && !pwrite |-> prdata[4:0] == 5'h00
		&& prdata[31:8] == 24'h0) else $error("unused bits read nonzero");
endmodule // rsmc_props
bind rsmc_top rsmc_props rsmc_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .supply_above, .supply_monitor_enable, .supply_threshold_select,
	.rst_pin_oe, .core_rst_n, .core);

// [tb/rsmc_supply_model.sv]
/* Supply comparator model: output follows the commanded supply level.
 Assumes the bench drives level_ok from time zero. */
`timescale 1ns/1ns
module rsmc_supply_model (
	input wire logic pclk,
	input wire logic level_ok,
	input wire logic slow,
	output logic     supply_above
);
	logic [3:0] dly_q;
	// Slow mode models a sluggish comparator
	always_ff @(posedge pclk) dly_q <= {dly_q[2:0], level_ok};
	assign supply_above = slow ? dly_q[3] : dly_q[0];
endmodule // rsmc_supply_model

// [tb/tb_rsmc_top.sv]
/* Self-checking bench for rsmc_top over APB.
 Assumes the comparator model on supply_above. */
`timescale 1ns/1ns
module tb_rsmc_top;
	import rsmc_pkg::*;
	localparam int DLY = 20;
	logic        pclk, presetn, psel, penable, pwrite, level_ok, slow;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic        pready, pslverr, sup, en, thr, pin_o, pin_oe, core_rst_n, er;
	rsmc_core_t  core;
	int          num_errors, n_tests, cyc, n;
	logic [7:0]  v;
	int          m_en, m_up, m_thr;
	logic [7:0]  wq[$];
	function automatic logic [31:0] m_ctrl();
		return {24'h0, m_en[0], m_up[0], m_thr[0], 5'h00};
	endfunction
	rsmc_supply_model rsmc_supply_model_i (.pclk(pclk), .level_ok(level_ok), .slow(slow),
		.supply_above(sup));
	rsmc_top #(.POR_DELAY_CYC(DLY)) rsmc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .supply_above(sup), .supply_monitor_enable(en),
		.supply_threshold_select(thr), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
		.core_rst_n(core_rst_n), .core(core));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////////////
	task give_verdict();
		$display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 18'h0, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wait_rst(input logic lvl);
		n = 0;
		while (core_rst_n !== lvl && n < 300) begin
			@(posedge pclk) #1;
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
		{cyc, num_errors, n_tests} = '0;
		level_ok = 1;
		void'($urandom(10));
		repeat (10) @(posedge pclk);
		presetn <= 1;
		wait_rst(1);
		chk(n >= DLY && n < DLY + 12, 1);
		m_en = 1;
		m_up = 1;
		m_thr = 0;
		apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, m_ctrl());
		apb(0, RSMC_ADDR_CAUSE, 0); chk(rd[1], 1);
		chk(pin_o, 0);
		$display("power-on test done");
		repeat (4) begin
			v = 8'($urandom) | 8'h80;
			wq.push_back(v);
			apb(1, RSMC_ADDR_MON_CTRL, {24'h0, v});
			v = wq.pop_front();
			m_thr = v[5];
			apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, m_ctrl());
			chk(thr, m_thr[0]);
		end
		$display("control test done");
		apb(1, RSMC_ADDR_MON_CTRL, 32'h80);
		m_thr = 0;
		slow <= 1;
		level_ok <= 0;
		wait_rst(0); chk(pin_oe, 1);
		repeat (10) @(posedge pclk);
		chk(core_rst_n, 0);
		level_ok <= 1;
		wait_rst(1); chk(n < DLY, 1);
		apb(0, RSMC_ADDR_CAUSE, 0); chk(rd[1], 1);
		apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, m_ctrl());
		$display("monitor fault test done");
		apb(1, RSMC_ADDR_MON_CTRL, 0);
		apb(1, RSMC_ADDR_CAUSE, 32'h10);
		wait_rst(0); chk(pin_oe, 0);
		wait_rst(1);
		apb(0, RSMC_ADDR_CAUSE, 0); chk(rd[4:1], 4'h8);
		apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, 32'h40);
		level_ok <= 0;
		repeat (12) @(posedge pclk);
		chk(core_rst_n, 1);
		apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, 32'h00);
		$display("software reset test done");
		level_ok <= 1;
		@(posedge pclk);
		presetn <= 0;
		#1 chk(core_rst_n, 0);
		repeat (3) @(posedge pclk);
		presetn <= 1;
		wait_rst(1);
		m_en = 1;
		m_thr = 0;
		apb(0, RSMC_ADDR_MON_CTRL, 0); chk(rd, m_ctrl());
		apb(1, RSMC_ADDR_CAUSE, 32'h02);
		repeat (8) @(posedge pclk);
		chk(core_rst_n, 1);
		apb(0, RSMC_ADDR_CORE_STAT, 0); chk(rd, 32'h5);
		apb(0, 14'h0008, 0); chk(er, 1);
		$display("second power-on test done");
		give_verdict();
	end
endmodule // tb_rsmc_top
